/* logic/pbd_dim_sensor.sv */
// dim sensor input: press timing, switch and 4-bit dimming telegrams
// Notes on behaviour
// [R01] block object enabled and set ignores contact
// [R02] cyclic switch resend continues while blocked
// [R03] react immediately on an accepted edge
// [R04] ignore edges for selectable debounce interval
// [R05] polarity selects closed or opened as actuation
// [R06] dim-and-switch: long dims, short switches
// [R07] dim-only: dim telegram at once, no classification
// [R08] alternating: switch off means brighter, else opposite
// [R09] switch object writable from the bus
// [R10] long press threshold 0.3 s to 10 s
// [R11] short press: toggle, on, off or nothing
// [R12] long press: brighter, darker or alternating
// [R13] after-on variants: first long uses configured direction
// [R14] start/stop: one start telegram, stop ends
// [R15] dim code: 0000/1000 stop, 0001 darker, 1001 brighter
// [R16] stepped: repeat while long press lasts
// [R17] stepped: selectable step 100 to 1.56 percent
// [R18] stepped: repeat interval 0.3 s to 10 s
// [R19] two-button dimming via two instances
// [R20] release before threshold is short; long fires once
// [R21] step selection maps to codes 1 to 7
// [R22] start/stop: stop sent on long release
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module pbd_dim_sensor
  import pbd_pkg::*;
#(
  parameter int TICK_CYC = MS_TICK_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic contact_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DW-1:0] rdata_out,
  output logic sw_tel_valid_out,
  output logic sw_tel_value_out,
  output logic dim_tel_valid_out,
  output logic [3:0] dim_tel_code_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [6:0] TENTH_LAST = 7'(TENTH_MS - 1);
  localparam logic [3:0] SEC_LAST = 4'(SEC_TENTHS - 1);

  pbd_cfg_s cfg_ff;
  pbd_timing_s timing_ff;
  logic [DW-1:0] cyc_period_ff;
  logic sw_obj_ff;
  logic block_obj_ff;
  logic [DW-1:0] rdata_ff;

  logic [TICK_W-1:0] ms_cnt_ff;
  logic ms_tick_ff;
  logic [6:0] tenth_cnt_ff;
  logic tenth_tick_ff;
  logic [3:0] sec_cnt_ff;
  logic sec_tick_ff;

  pbd_state_e state_ff;
  logic [7:0] press_tmr_ff;
  logic last_bright_ff;
  logic first_after_on_ff;
  logic [DW-1:0] cyc_cnt_ff;

  logic sw_valid_ff;
  logic sw_value_ff;
  pbd_dim_tel_s dim_ff;

  logic act;
  logic press;
  logic release_ev;
  logic blocked;
  logic nxt_bright;
  logic [2:0] step_code;
  logic [7:0] long_load;
  logic [7:0] cycle_load;
  logic tmr_done;
  logic short_ev;
  logic long_ev;
  logic repeat_ev;
  logic stop_ev;
  logic short_sends;
  logic short_value;
  logic cyc_ev;

  // ----------------------------------------------------------------
  // contact front end
  // ----------------------------------------------------------------
  assign blocked = cfg_ff.block_en && block_obj_ff; // R01

  pbd_debounce u_debounce (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .contact_in(contact_in),
    .polarity_in(cfg_ff.polarity),
    .block_in(blocked),
    .ms_tick_in(ms_tick_ff),
    .deb_ms_in(deb_ms(timing_ff.deb_sel)),
    .act_out(act),
    .press_out(press),
    .release_out(release_ev)
  );

  // ----------------------------------------------------------------
  // time base: 1 ms, 100 ms and 1 s enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ms_cnt_ff <= '0;
      ms_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff <= (ms_cnt_ff == TICK_LAST);
      ms_cnt_ff <= (ms_cnt_ff == TICK_LAST) ? '0 : ms_cnt_ff + 1'b1;
    end
  end

  // tenth-of-second tick divides the ms tick
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tenth_cnt_ff <= 7'h00;
      tenth_tick_ff <= 1'b0;
    end else begin
      tenth_tick_ff <= ms_tick_ff && (tenth_cnt_ff == TENTH_LAST);
      if (ms_tick_ff) begin
        tenth_cnt_ff <= (tenth_cnt_ff == TENTH_LAST) ? 7'h00 : tenth_cnt_ff + 7'h01;
      end
    end
  end

  // second tick for the cyclic resend period
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sec_cnt_ff <= 4'h0;
      sec_tick_ff <= 1'b0;
    end else begin
      sec_tick_ff <= tenth_tick_ff && (sec_cnt_ff == SEC_LAST);
      if (tenth_tick_ff) begin
        sec_cnt_ff <= (sec_cnt_ff == SEC_LAST) ? 4'h0 : sec_cnt_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cfg_ff <= pbd_cfg_s'(CFG_RST);
      timing_ff <= pbd_timing_s'(TIMING_RST);
      cyc_period_ff <= CYCLIC_RST;
    end else if (wr_in) begin
      if (addr_in == ADDR_CFG) begin
        cfg_ff <= pbd_cfg_s'(wdata_in[CFG_W-1:0]);
      end
      if (addr_in == ADDR_TIMING) begin
        timing_ff <= pbd_timing_s'(wdata_in[TIMING_W-1:0]);
      end
      if (addr_in == ADDR_CYCLIC) begin
        cyc_period_ff <= wdata_in;
      end
    end
  end

  // block object is a plain software bit
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      block_obj_ff <= 1'b0;
    end else if (wr_in && (addr_in == ADDR_OBJ)) begin
      block_obj_ff <= wdata_in[OBJ_BLOCK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // register reads, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_ff <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        ADDR_CFG: rdata_ff <= DW'(cfg_ff);
        ADDR_TIMING: rdata_ff <= DW'(timing_ff);
        ADDR_CYCLIC: rdata_ff <= cyc_period_ff;
        ADDR_OBJ: rdata_ff <= DW'({block_obj_ff, sw_obj_ff});
        ADDR_STATUS: rdata_ff <= DW'({state_ff, first_after_on_ff, last_bright_ff, blocked, act});
        default: rdata_ff <= '0; // unmapped reads zero
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata_out = rdata_ff;

  // ----------------------------------------------------------------
  // press classification and dimming state
  // ----------------------------------------------------------------
  // loads carry one extra tick so the threshold is never undershot
  assign long_load = {1'b0, tenths(timing_ff.long_sel)} + 8'h01; // R10
  assign cycle_load = {1'b0, tenths(timing_ff.cycle_sel)} + 8'h01; // R18
  assign tmr_done = (press_tmr_ff == 8'h01) && tenth_tick_ff;

  assign short_ev = (state_ff == ST_TIMING) && release_ev; // R20
  assign long_ev = ((state_ff == ST_TIMING) && tmr_done && act && !release_ev) // R20 R06
    || ((state_ff == ST_IDLE) && press && cfg_ff.only_dim); // R07
  assign repeat_ev = (state_ff == ST_DIMMING) && cfg_ff.dim_steps && tmr_done && !release_ev; // R16
  assign stop_ev = (state_ff == ST_DIMMING) && release_ev && !cfg_ff.dim_steps; // R22 R14

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (press) begin
            state_ff <= cfg_ff.only_dim ? ST_DIMMING : ST_TIMING; // R07 R06
          end
        end
        ST_TIMING: begin
          if (release_ev) begin
            state_ff <= ST_IDLE;
          end else if (long_ev) begin
            state_ff <= ST_DIMMING;
          end
        end
        ST_DIMMING: begin
          if (release_ev) begin
            state_ff <= ST_IDLE; // R16
          end
        end
      endcase
    end
  end

  // one shared 100 ms timer: long threshold, then repeat interval
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      press_tmr_ff <= 8'h00;
    end else if ((state_ff == ST_IDLE) && press && !cfg_ff.only_dim) begin
      press_tmr_ff <= long_load;
    end else if (long_ev || repeat_ev) begin
      press_tmr_ff <= cycle_load; // R18
    end else if (tenth_tick_ff && (press_tmr_ff != 8'h00)) begin
      press_tmr_ff <= press_tmr_ff - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // dimming direction decision
  // ----------------------------------------------------------------
  always_comb begin
    nxt_bright = 1'b1;
    unique case (cfg_ff.long_dir)
      DIR_BRIGHTER: nxt_bright = 1'b1; // R12
      DIR_DARKER: nxt_bright = 1'b0; // R12
      DIR_ALT: nxt_bright = !sw_obj_ff || !last_bright_ff; // R08 R12
      DIR_ALT_BR_ON: nxt_bright = first_after_on_ff ? 1'b1 : (!sw_obj_ff || !last_bright_ff); // R13
      DIR_ALT_DK_ON: nxt_bright = first_after_on_ff ? 1'b0 : (!sw_obj_ff || !last_bright_ff); // R13
      default: nxt_bright = 1'b1; // unused config codes dim brighter
    endcase
  end

  // step selection 0..6 maps to codes 1..7, 100 % down to 1.56 %
  assign step_code = (cfg_ff.step_sel == DIM_STEP_MAX) ? DIM_STEP_MAX : cfg_ff.step_sel + 3'h1; // R21 R17

  // last direction sent, remembered for the alternating modes
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      last_bright_ff <= 1'b0;
    end else if (long_ev) begin
      last_bright_ff <= nxt_bright;
    end
  end

  // armed by a short press that sends ON, consumed by the next long press
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      first_after_on_ff <= 1'b0;
    end else if (short_ev && short_sends && short_value) begin
      first_after_on_ff <= 1'b1; // R13
    end else if (long_ev) begin
      first_after_on_ff <= 1'b0; // R13
    end
  end

  // ----------------------------------------------------------------
  // switch object and short press reaction
  // ----------------------------------------------------------------
  always_comb begin
    short_sends = 1'b1;
    short_value = 1'b0;
    unique case (cfg_ff.short_act)
      SHORT_ON: short_value = 1'b1; // R11
      SHORT_OFF: short_value = 1'b0; // R11
      SHORT_TOGGLE: short_value = !sw_obj_ff; // R11
      SHORT_NONE: short_sends = 1'b0; // R11
    endcase
  end

  // local short press wins over a bus write in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sw_obj_ff <= 1'b0;
    end else if (short_ev && short_sends) begin
      sw_obj_ff <= short_value; // R11 R06
    end else if (wr_in && (addr_in == ADDR_OBJ)) begin
      sw_obj_ff <= wdata_in[OBJ_SW_BIT]; // R09
    end
  end

  // ----------------------------------------------------------------
  // cyclic resend of the switch state, independent of blocking
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cyc_cnt_ff <= '0;
    end else if (!cfg_ff.cyclic_en) begin
      cyc_cnt_ff <= '0;
    end else if (sec_tick_ff) begin
      cyc_cnt_ff <= cyc_ev ? '0 : cyc_cnt_ff + 1'b1; // R02
    end
  end

  // a zero period would flood the bus, so it acts as one second
  assign cyc_ev = cfg_ff.cyclic_en && sec_tick_ff && ((cyc_cnt_ff + 1'b1) >= cyc_period_ff); // R02

  // ----------------------------------------------------------------
  // telegram outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sw_valid_ff <= 1'b0;
      sw_value_ff <= 1'b0;
    end else if (short_ev && short_sends) begin
      sw_valid_ff <= 1'b1; // R03
      sw_value_ff <= short_value;
    end else if (cyc_ev) begin
      sw_valid_ff <= 1'b1; // R02
      sw_value_ff <= sw_obj_ff;
    end else begin
      sw_valid_ff <= 1'b0;
    end
  end

  // start/stop always dims the full range; stepped carries the step
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      dim_ff <= '0;
    end else if (long_ev) begin
      dim_ff.valid <= 1'b1; // R03 R14
      dim_ff.code <= {nxt_bright, cfg_ff.dim_steps ? step_code : DIM_FULL}; // R15 R17
    end else if (repeat_ev) begin
      dim_ff.valid <= 1'b1; // R16
      dim_ff.code <= {last_bright_ff, step_code}; // R16 R17
    end else if (stop_ev) begin
      dim_ff.valid <= 1'b1; // R14 R22
      dim_ff.code <= {last_bright_ff, DIM_STOP}; // R15
    end else begin
      dim_ff.valid <= 1'b0;
    end
  end

  assign sw_tel_valid_out = sw_valid_ff;
  assign sw_tel_value_out = sw_value_ff;
  assign dim_tel_valid_out = dim_ff.valid;
  assign dim_tel_code_out = dim_ff.code;

  // two-button dimming: one instance per button, configured apart // R19

endmodule : pbd_dim_sensor

/* include/pbd_pkg.sv */
// constants, config layouts and lookup tables for the dim sensor input
package pbd_pkg;

  // ----------------------------------------------------------------
  // timing base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_TICK_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int TENTH_MS = 100; // one slow tick is 100 ms
  localparam int SEC_TENTHS = 10; // ten slow ticks make a second

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int AW = 3;
  localparam int DW = 16;
  localparam logic [AW-1:0] ADDR_CFG = 3'h0;
  localparam logic [AW-1:0] ADDR_TIMING = 3'h1;
  localparam logic [AW-1:0] ADDR_CYCLIC = 3'h2;
  localparam logic [AW-1:0] ADDR_OBJ = 3'h3;
  localparam logic [AW-1:0] ADDR_STATUS = 3'h4;
  localparam int CFG_W = 13;
  localparam int TIMING_W = 13;
  localparam logic [CFG_W-1:0] CFG_RST = 13'h090;
  localparam logic [TIMING_W-1:0] TIMING_RST = 13'h31B;
  localparam logic [DW-1:0] CYCLIC_RST = 16'h003C;
  localparam int OBJ_SW_BIT = 0;
  localparam int OBJ_BLOCK_BIT = 1;

  // ----------------------------------------------------------------
  // telegram encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] DIM_STOP = 3'h0;
  localparam logic [2:0] DIM_FULL = 3'h1;
  localparam logic [2:0] DIM_STEP_MAX = 3'h7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SHORT_ON, SHORT_OFF, SHORT_TOGGLE, SHORT_NONE} pbd_short_e;
  typedef enum logic [2:0] {DIR_BRIGHTER, DIR_DARKER, DIR_ALT, DIR_ALT_BR_ON, DIR_ALT_DK_ON} pbd_dir_e;
  typedef enum logic [1:0] {ST_IDLE, ST_TIMING, ST_DIMMING} pbd_state_e;

  typedef struct packed {
    logic cyclic_en;
    logic [2:0] step_sel;
    logic dim_steps;
    pbd_dir_e long_dir;
    pbd_short_e short_act;
    logic only_dim;
    logic block_en;
    logic polarity;
  } pbd_cfg_s;

  typedef struct packed {
    logic [4:0] cycle_sel;
    logic [4:0] long_sel;
    logic [2:0] deb_sel;
  } pbd_timing_s;

  typedef struct packed {
    logic valid;
    logic [3:0] code;
  } pbd_dim_tel_s;

  // ----------------------------------------------------------------
  // lookup tables
  // ----------------------------------------------------------------
  // debounce interval in ms
  function automatic logic [7:0] deb_ms(input logic [2:0] sel);
    logic [7:0] r;
    r = 8'h96;
    case (sel)
      3'h0: r = 8'h0A;
      3'h1: r = 8'h14;
      3'h2: r = 8'h1E;
      3'h3: r = 8'h32;
      3'h4: r = 8'h46;
      3'h5: r = 8'h64;
      default: r = 8'h96;
    endcase
    return r;
  endfunction : deb_ms

  // 0.3 s .. 10 s in tenths of a second
  function automatic logic [6:0] tenths(input logic [4:0] sel);
    logic [6:0] r;
    r = 7'h64;
    case (sel)
      5'h00: r = 7'h03;
      5'h01: r = 7'h04;
      5'h02: r = 7'h05;
      5'h03: r = 7'h06;
      5'h04: r = 7'h08;
      5'h05: r = 7'h0A;
      5'h06: r = 7'h0C;
      5'h07: r = 7'h0F;
      5'h08: r = 7'h14;
      5'h09: r = 7'h1E;
      5'h0A: r = 7'h28;
      5'h0B: r = 7'h32;
      5'h0C: r = 7'h3C;
      5'h0D: r = 7'h46;
      5'h0E: r = 7'h50;
      5'h0F: r = 7'h5A;
      default: r = 7'h64;
    endcase
    return r;
  endfunction : tenths

endpackage : pbd_pkg

/* logic/pbd_debounce.sv */
// contact synchroniser, polarity, blocking and edge lockout
`timescale 1ns/100ps
module pbd_debounce
  import pbd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic contact_in,
  input wire logic polarity_in,
  input wire logic block_in,
  input wire logic ms_tick_in,
  input wire logic [7:0] deb_ms_in,
  output logic act_out,
  output logic press_out,
  output logic release_out
);

  logic sync1_ff;
  logic sync2_ff;
  logic act_ff;
  logic press_ff;
  logic release_ff;
  logic [8:0] lock_ff;
  logic level;
  logic take;

  // ----------------------------------------------------------------
  // two-stage synchroniser, contact is asynchronous
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= contact_in;
      sync2_ff <= sync1_ff;
    end
  end

  // opened-contact polarity inverts the closed level
  assign level = sync2_ff ^ polarity_in; // R05
  // react on the edge itself, not after the interval
  assign take = (lock_ff == 9'h000) && !block_in && (level != act_ff); // R01 R03

  // ----------------------------------------------------------------
  // accepted level and edge pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      act_ff <= 1'b0;
      press_ff <= 1'b0;
      release_ff <= 1'b0;
    end else begin
      act_ff <= take ? level : act_ff;
      press_ff <= take && level;
      release_ff <= take && !level;
    end
  end

  // ----------------------------------------------------------------
  // lockout counter; one extra tick so the interval is never short
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      lock_ff <= 9'h000;
    end else if (take) begin
      lock_ff <= {1'b0, deb_ms_in} + 9'h001; // R04
    end else if (ms_tick_in && (lock_ff != 9'h000)) begin
      lock_ff <= lock_ff - 9'h001; // R04
    end
  end

  assign act_out = act_ff;
  assign press_out = press_ff;
  assign release_out = release_ff;

endmodule : pbd_debounce

/* verif/pbd_dim_sensor_sva.sv */
// port checker for the dim sensor input
`timescale 1ns/100ps
module pbd_dim_sensor_sva
  import pbd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic contact_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [DW-1:0] rdata_out,
  input wire logic sw_tel_valid_out,
  input wire logic sw_tel_value_out,
  input wire logic dim_tel_valid_out,
  input wire logic [3:0] dim_tel_code_out
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_rd_slot_only: assert property (!$past(rd_in) |-> rdata_out == '0)
    else $error("rdata off slot");
  a_rd_unmapped: assert property (rd_in && addr_in > ADDR_STATUS |=> rdata_out == '0)
    else $error("unmapped nonzero");
  a_obj_readback: assert property (wr_in && addr_in == ADDR_OBJ ##2 rd_in && addr_in == ADDR_OBJ
    |=> rdata_out[1:0] == $past(wdata_in[1:0], 3)) else $error("object write lost");
  a_sw_one_cycle: assert property (sw_tel_valid_out |=> !sw_tel_valid_out)
    else $error("sw pulse long");
  a_dim_lockout: assert property (dim_tel_valid_out |=> !dim_tel_valid_out [*8])
    else $error("dim too close");
  a_code_holds: assert property (!dim_tel_valid_out |-> $stable(dim_tel_code_out))
    else $error("dim code moved");
  a_value_holds: assert property (!sw_tel_valid_out |-> $stable(sw_tel_value_out))
    else $error("sw value moved");
  a_quiet_start: assert property ($rose(rstn_in) |-> !sw_tel_valid_out && !dim_tel_valid_out)
    else $error("send at reset");

  // main scenarios seen
  c_switch: cover property (sw_tel_valid_out);
  c_bright: cover property (dim_tel_valid_out && dim_tel_code_out[3]);
  c_stop: cover property (dim_tel_valid_out && dim_tel_code_out[2:0] == DIM_STOP);
endmodule : pbd_dim_sensor_sva

bind pbd_dim_sensor pbd_dim_sensor_sva u_sva (.clk_in(clk_in), .rstn_in(rstn_in),
  .contact_in(contact_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .sw_tel_valid_out(sw_tel_valid_out), .sw_tel_value_out(sw_tel_value_out),
  .dim_tel_valid_out(dim_tel_valid_out), .dim_tel_code_out(dim_tel_code_out));

/* verif/pbd_actuator_model.sv */
// behavioural dimming actuator fed by the sensor's telegrams
`timescale 1ns/100ps
module pbd_actuator_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sw_valid_in,
  input wire logic sw_value_in,
  input wire logic dim_valid_in,
  input wire logic [3:0] dim_code_in,
  output logic sw_state_out,
  output logic [7:0] sw_cnt_out,
  output logic [7:0] dim_cnt_out,
  output logic [3:0] dim_last_out
);
  // switch state as last sent
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sw_state_out <= 1'h0;
      sw_cnt_out <= 8'h00;
    end else if (sw_valid_in) begin
      sw_state_out <= sw_value_in;
      sw_cnt_out <= sw_cnt_out + 8'h01;
    end
  end
  // dim log; counts wrap
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      dim_cnt_out <= 8'h00;
      dim_last_out <= 4'h0;
    end else if (dim_valid_in) begin
      dim_cnt_out <= dim_cnt_out + 8'h01;
      dim_last_out <= dim_code_in;
    end
  end
endmodule : pbd_actuator_model

/* verif/pbd_dim_sensor_bench.sv */
// self-checking bench for the dim sensor input
`timescale 1ns/100ps
module pbd_dim_sensor_bench;
  import pbd_pkg::*;
  logic clk_in, rstn_in, contact_in, wr_in, rd_in, sw_v, sw_val, dim_v, sw_state, obj;
  logic [AW-1:0] addr_in;
  logic [DW-1:0] wdata_in, rdata_out;
  logic [3:0] dim_code, dim_last;
  logic [7:0] sw_cnt, dim_cnt;
  logic [31:0] seed;
  logic [4:0] r;
  logic [2:0] st;
  int fails, check_count;

  // ----------------------------------------------------------------
  // clock, design and actuator
  // ----------------------------------------------------------------
  always #5 clk_in = ~clk_in;
  pbd_dim_sensor #(.TICK_CYC(10)) u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .contact_in(contact_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .sw_tel_valid_out(sw_v), .sw_tel_value_out(sw_val), .dim_tel_valid_out(dim_v),
    .dim_tel_code_out(dim_code));
  pbd_actuator_model u_act (.clk_in(clk_in), .rstn_in(rstn_in), .sw_valid_in(sw_v),
    .sw_value_in(sw_val), .dim_valid_in(dim_v), .dim_code_in(dim_code), .sw_state_out(sw_state),
    .sw_cnt_out(sw_cnt), .dim_cnt_out(dim_cnt), .dim_last_out(dim_last));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] mk(input logic p, b, o, input logic [1:0] s, input logic [2:0] d,
    input logic m, input logic [2:0] t, input logic c);
    return {3'h0, c, t, m, d, s, o, b, p};
  endfunction : mk
  function automatic logic [15:0] rst_val(input int a);
    return a == 0 ? 16'h0090 : a == 1 ? 16'h031B : a == 2 ? 16'h003C : 16'h0000;
  endfunction : rst_val
  // short press reaction as {sent, value}
  function automatic logic [4:0] exp_short(input logic [1:0] s, input logic o);
    return s == 2'h0 ? 5'h11 : s == 2'h1 ? 5'h10 : s == 2'h2 ? {4'h8, !o} : 5'h00;
  endfunction : exp_short
  task automatic wrap_up();
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk_reg(input logic [15:0] g, e);
    check_count++;
    if (g !== e) begin fails++; $display("[FAIL] %0t reg %h exp %h", $time, g, e); end
  endtask : chk_reg
  task automatic chk_tel(input logic [4:0] g, e);
    check_count++;
    if (g !== e) begin fails++; $display("[FAIL] %0t tel %h exp %h", $time, g, e); end
  endtask : chk_tel
  task automatic tk(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tk
  // one strobe cycle
  task automatic acc(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_in);
    wr_in <= w; rd_in <= !w; addr_in <= a; wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 0; rd_in <= 0;
  endtask : acc
  task automatic rd_reg(input logic [AW-1:0] a, input logic [15:0] e);
    acc(0, a, '0);
    #1 chk_reg(rdata_out, e);
  endtask : rd_reg
  task automatic set_c(input logic v);
    @(posedge clk_in);
    contact_in <= v;
  endtask : set_c
  // bounded wait: {seen, code}
  task automatic wait_tel(input logic dm, input int lim, output logic [4:0] q);
    logic [7:0] c0;
    int n;
    c0 = dm ? dim_cnt : sw_cnt;
    n = 0;
    while ((dm ? dim_cnt : sw_cnt) === c0 && n < lim) begin @(posedge clk_in); #1; n++; end
    q = {n < lim, dm ? dim_last : {3'h0, sw_state}};
  endtask : wait_tel
  task automatic long_press(input logic [3:0] e);
    logic [4:0] q;
    set_c(1);
    wait_tel(1, 4200, q);
    chk_tel(q, {1'h1, e});
    set_c(0);
    tk(200);
  endtask : long_press

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    clk_in = 0; rstn_in = 0; contact_in = 0; wr_in = 0; rd_in = 0; addr_in = '0; wdata_in = '0;
    fails = 0; check_count = 0; seed = 32'd3451; obj = 0;
    tk(6);
    rstn_in <= 1;
    for (int i = 0; i < 8; i++) if (i != 4) rd_reg(AW'(i), rst_val(i));
    acc(1, ADDR_CFG, 16'(rnd()));
    rd_reg(ADDR_CFG, {3'h0, seed[12:0]});
    acc(1, ADDR_TIMING, '0);
    // dim only, both polarities
    for (int k = 0; k < 2; k++) begin
      acc(1, ADDR_CFG, mk(k[0], 0, 1, 3, k[2:0], 0, 0, 0));
      if (k == 0) set_c(1);
      wait_tel(1, 20, r);
      chk_tel(r, {2'h1, k == 0, 3'h1});
      tk(150);
      set_c(k[0]);
      wait_tel(1, 20, r);
      chk_tel(r, {2'h1, k == 0, 3'h0});
      tk(150);
    end
    rstn_in <= 0;
    contact_in <= 0;
    tk(6);
    rstn_in <= 1;
    // bounce in lockout ignored; short interval keeps the run brief
    acc(1, ADDR_TIMING, '0);
    acc(1, ADDR_CFG, mk(0, 0, 1, 3, 0, 0, 0, 0));
    set_c(1);
    wait_tel(1, 20, r);
    tk(20);
    set_c(0);
    tk(20);
    set_c(1);
    wait_tel(1, 300, r);
    chk_tel(r[4], 5'h00);
    set_c(0);
    tk(150);
    // each short reaction
    for (int s = 0; s < 4; s++) begin
      obj = rnd();
      acc(1, ADDR_OBJ, {15'h0, obj});
      rd_reg(ADDR_OBJ, {15'h0, obj});
      acc(1, ADDR_CFG, mk(0, 0, 0, s[1:0], 0, 0, 0, 0));
      set_c(1);
      tk(200);
      set_c(0);
      wait_tel(0, 30, r);
      chk_tel(s == 3 ? 5'(r[4]) : r, exp_short(s[1:0], obj));
      tk(150);
    end
    // stepped alternating
    st = 3'(rnd() % 7);
    acc(1, ADDR_CFG, mk(0, 0, 0, 3, 2, 1, st, 0));
    acc(1, ADDR_OBJ, '0);
    set_c(1);
    wait_tel(1, 4200, r);
    chk_tel(r, {2'h3, st + 3'h1});
    wait_tel(1, 4200, r);
    chk_tel(r, {2'h3, st + 3'h1});
    set_c(0);
    wait_tel(1, 5000, r);
    chk_tel(r[4], 5'h00);
    acc(1, ADDR_OBJ, 1);
    long_press({1'h0, st + 3'h1});
    // darker first after on
    acc(1, ADDR_CFG, mk(0, 0, 0, 0, 4, 1, st, 0));
    set_c(1);
    tk(200);
    set_c(0);
    tk(200);
    long_press({1'h0, st + 3'h1});
    long_press({1'h1, st + 3'h1});
    // blocked, cyclic resend runs
    acc(1, ADDR_CYCLIC, 1);
    acc(1, ADDR_OBJ, 3);
    acc(1, ADDR_CFG, mk(0, 1, 1, 3, 0, 0, 0, 1));
    set_c(1);
    wait_tel(1, 300, r);
    chk_tel(r[4], 5'h00);
    set_c(0);
    wait_tel(0, 12000, r);
    chk_tel(r, 5'h11);
    wrap_up();
  end

  // hang guard
  initial begin
    tk(100000);
    fails++;
    wrap_up();
  end
endmodule : pbd_dim_sensor_bench
